// File: rtl/iprc_pkg.sv
/*
 * Package for the serial-error / PWM-fault-B priority register block.
 * Holds offsets, field positions, reset values and the bundled types.
 * Assumes a 32-bit classic Wishbone slave port with word addressing by byte.
 */
package iprc_pkg;

    // Register map
    localparam logic [7:0]  IPRC_PRIO_OFFSET   = 8'h00;  // Priority register, byte address
    localparam logic [7:0]  IPRC_STATUS_OFFSET = 8'h04;  // Effective level view, read only

    // Field positions inside the priority register
    localparam int          IPRC_S2_LSB        = 8;
    localparam int          IPRC_S1_LSB        = 4;
    localparam int          IPRC_FB_LSB        = 0;
    localparam int          IPRC_LVL_W         = 3;

    // Value after reset: each field powers up at level 4
    localparam logic [2:0]  IPRC_LVL_RESET     = 3'h4;
    localparam logic [2:0]  IPRC_LVL_OFF       = 3'h0;
    localparam logic [2:0]  IPRC_LVL_MAX       = 3'h7;

    // Mask of implemented bits
    localparam logic [15:0] IPRC_IMPL_MASK     = 16'h0777;

    // Source indices
    localparam int          IPRC_NSRC          = 3;

    // Per-source requests and presentation
    typedef struct packed {
        logic serial2_err;
        logic serial1_err;
        logic pwm_fault_b;
    } iprc_src_t;

    // Winner presented to the processor
    typedef struct packed {
        logic       valid;
        logic [1:0] src;
        logic [2:0] level;
    } iprc_win_t;

    // Field bundle
    typedef struct packed {
        logic [2:0] serial2_error_priority;
        logic [2:0] serial1_error_priority;
        logic [2:0] pwm_fault_b_priority;
    } iprc_prio_t;

endpackage : iprc_pkg

// File: rtl/iprc_arbiter.sv
/*
 * Priority arbitration among the three sources governed by the register.
 * Assumes requests are synchronous to clk_i and fields come from the register.
 */
module iprc_arbiter
    import iprc_pkg::*;
(
    // Inputs
    input  wire iprc_pkg::iprc_prio_t prio_i,
    input  wire iprc_pkg::iprc_src_t  req_i,
    // Result
    output iprc_pkg::iprc_win_t       win_o
);

    // Compare a candidate against the best so far; level 0 never wins
    function automatic iprc_win_t pick(input iprc_win_t best, input logic r,
                                       input logic [2:0] lvl, input logic [1:0] id);
        iprc_win_t res;
        res = best;
        if (r && (lvl != IPRC_LVL_OFF) && (!best.valid || lvl > best.level)) begin
            res.valid = 1'b1;
            res.src   = id;
            res.level = lvl;                               // Code maps to its binary level
        end
        return res;
    endfunction

    // Ties go to the serial-2 source, then serial-1, then fault B
    always_comb begin
        iprc_win_t w;
        w     = '0;
        w     = pick(w, req_i.serial2_err, prio_i.serial2_error_priority, 2'h2);
        w     = pick(w, req_i.serial1_err, prio_i.serial1_error_priority, 2'h1);
        w     = pick(w, req_i.pwm_fault_b, prio_i.pwm_fault_b_priority, 2'h0);
        win_o = w;
    end

endmodule // iprc_arbiter

// File: rtl/iprc_regblock.sv
/*
 * Interrupt priority register for serial error and PWM fault B sources,
 * with a classic Wishbone slave and registered arbitration result.
 * Assumes one clock, synchronous active-high reset, requests on clk_i.
 */
// The Wishbone slave port and the address map were left to the implementer.
module iprc_regblock
    import iprc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Interrupt sources and result
    input  wire iprc_pkg::iprc_src_t req_i,
    output iprc_pkg::iprc_prio_t     prio_o,
    output iprc_pkg::iprc_win_t      win_o
);
    import iprc_pkg::*;

    iprc_prio_t  prio_reg;
    iprc_prio_t  prio_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    iprc_win_t   win_reg;
    iprc_win_t   win_next;
    iprc_win_t   win_comb;
    logic        acc;

    // Pack the fields into their register image; other bits stay zero
    function automatic logic [15:0] image(input iprc_prio_t p);
        logic [15:0] v;
        v = 16'h0000;
        v[IPRC_S2_LSB +: IPRC_LVL_W] = p.serial2_error_priority;
        v[IPRC_S1_LSB +: IPRC_LVL_W] = p.serial1_error_priority;
        v[IPRC_FB_LSB +: IPRC_LVL_W] = p.pwm_fault_b_priority;
        return v & IPRC_IMPL_MASK;
    endfunction

    // A new access starts only when no ack is out, giving one-wait-state answers
    assign acc = wb_cyc_i && wb_stb_i && !ack_reg;

    // Register, ack and read data next-state
    always_comb begin
        prio_next = prio_reg;
        ack_next  = acc;
        dat_next  = dat_reg;
        if (acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET) begin
            // Byte lanes: sel[1] carries bits 10:8, sel[0] bits 6:0
            if (wb_sel_i[1]) begin
                prio_next.serial2_error_priority = wb_dat_i[IPRC_S2_LSB +: IPRC_LVL_W];
            end
            if (wb_sel_i[0]) begin
                prio_next.serial1_error_priority = wb_dat_i[IPRC_S1_LSB +: IPRC_LVL_W];
                prio_next.pwm_fault_b_priority   = wb_dat_i[IPRC_FB_LSB +: IPRC_LVL_W];
            end
        end
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                IPRC_PRIO_OFFSET:   dat_next = {16'h0000, image(prio_reg)};
                IPRC_STATUS_OFFSET: dat_next = {26'h000_0000, win_reg};
                default:            dat_next = 32'h0000_0000;            // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_reg <= '{IPRC_LVL_RESET, IPRC_LVL_RESET, IPRC_LVL_RESET};
            ack_reg  <= 1'b0;
            dat_reg  <= 32'h0000_0000;
        end else begin
            prio_reg <= prio_next;
            ack_reg  <= ack_next;
            dat_reg  <= dat_next;
        end
    end

    // Arbitration; registered so the result is glitch free to the core
    iprc_arbiter u_arb (
        .prio_i (prio_reg),
        .req_i  (req_i),
        .win_o  (win_comb)
    );

    always_comb begin
        win_next = win_comb;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_reg <= '0;
        end else begin
            win_reg <= win_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign prio_o   = prio_reg;
    assign win_o    = win_reg;

    // Checks
    write_s2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET && wb_sel_i[1]
        |=> prio_reg.serial2_error_priority == $past(wb_dat_i[10:8]))
        else $error("serial-2 field did not take write");
    write_s1_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET && wb_sel_i[0]
        |=> prio_reg.serial1_error_priority == $past(wb_dat_i[6:4]))
        else $error("serial-1 field did not take write");
    write_fb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET && wb_sel_i[0]
        |=> prio_reg.pwm_fault_b_priority == $past(wb_dat_i[2:0]))
        else $error("fault B field did not take write");
    top_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.serial2_err && prio_reg.serial2_error_priority == 3'h7
        |=> win_reg.valid && win_reg.level == 3'h7)
        else $error("level 7 source not presented at 7");
    low_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        win_comb.valid && win_comb.level == 3'h1 |-> !(req_i.serial1_err
        && prio_reg.serial1_error_priority > 3'h1))
        else $error("level 1 beat a higher source");
    off_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_reg.pwm_fault_b_priority == 3'h0 |-> !(win_comb.valid && win_comb.src == 2'h0))
        else $error("disabled source presented");
    read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET
        |=> wb_ack_o && (wb_dat_o & 32'hFFFF_F888) == 32'h0000_0000)
        else $error("unused bits read nonzero");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // Reset puts every field at its power-up level and quiets the bus
    reset_value_a: assert property (@(posedge clk_i)
        rst_i |=> prio_o == {IPRC_LVL_RESET, IPRC_LVL_RESET, IPRC_LVL_RESET}
        && !wb_ack_o && wb_dat_o == 32'h0000_0000 && win_o == '0)
        else $error("state not at reset value after reset");

    // Every taken access is answered on the next edge, and nothing else is
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc |=> wb_ack_o)
        else $error("taken access not acked next cycle");
    no_stray_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !acc |=> !wb_ack_o)
        else $error("ack without a taken access");

    // Fields move only on a write to the priority offset, lane by lane
    hold_fields_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET) |=> $stable(prio_reg))
        else $error("fields changed without a write");
    lane_s2_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET && !wb_sel_i[1]
        |=> $stable(prio_reg.serial2_error_priority))
        else $error("serial-2 field changed with its lane off");
    lane_s1_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET && !wb_sel_i[0]
        |=> $stable(prio_reg.serial1_error_priority)
        && $stable(prio_reg.pwm_fault_b_priority))
        else $error("low fields changed with their lane off");

    // Priority reads carry the fields at their positions and zero elsewhere; status reads carry the winner
    read_image_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !wb_we_i && wb_adr_i == IPRC_PRIO_OFFSET
        |=> wb_dat_o == {21'h00_0000, $past(prio_reg.serial2_error_priority), 1'b0,
                         $past(prio_reg.serial1_error_priority), 1'b0,
                         $past(prio_reg.pwm_fault_b_priority)})
        else $error("priority read image wrong");
    status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !wb_we_i && wb_adr_i == IPRC_STATUS_OFFSET
        |=> wb_dat_o == {26'h000_0000, $past(win_reg)})
        else $error("status read does not show the winner");

    // Arbitration: only enabled, requesting sources, highest level first
    win_nonzero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        win_o.valid |-> win_o.level != IPRC_LVL_OFF)
        else $error("presented level is zero");
    win_highest_a: assert property (@(posedge clk_i) disable iff (rst_i)
        win_comb.valid |-> !(req_i.serial2_err && prio_reg.serial2_error_priority > win_comb.level)
        && !(req_i.serial1_err && prio_reg.serial1_error_priority > win_comb.level)
        && !(req_i.pwm_fault_b && prio_reg.pwm_fault_b_priority > win_comb.level))
        else $error("a higher level source lost");
    win_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        win_comb.valid |-> (win_comb.src == 2'h2 && req_i.serial2_err
            && win_comb.level == prio_reg.serial2_error_priority)
        || (win_comb.src == 2'h1 && req_i.serial1_err
            && win_comb.level == prio_reg.serial1_error_priority)
        || (win_comb.src == 2'h0 && req_i.pwm_fault_b
            && win_comb.level == prio_reg.pwm_fault_b_priority))
        else $error("presented level differs from the source code");
    win_present_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_i.serial2_err && prio_reg.serial2_error_priority != IPRC_LVL_OFF)
        || (req_i.serial1_err && prio_reg.serial1_error_priority != IPRC_LVL_OFF)
        || (req_i.pwm_fault_b && prio_reg.pwm_fault_b_priority != IPRC_LVL_OFF)
        |-> win_comb.valid)
        else $error("enabled request not presented");
    idle_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !req_i.serial2_err && !req_i.serial1_err && !req_i.pwm_fault_b |-> !win_comb.valid)
        else $error("winner without any request");
    s2_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_reg.serial2_error_priority == IPRC_LVL_OFF
        |-> !(win_comb.valid && win_comb.src == 2'h2))
        else $error("disabled serial-2 source presented");
    s1_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_reg.serial1_error_priority == IPRC_LVL_OFF
        |-> !(win_comb.valid && win_comb.src == 2'h1))
        else $error("disabled serial-1 source presented");
    win_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        win_comb.valid |-> win_comb.src != 2'h3)
        else $error("winner source code out of range");

endmodule // iprc_regblock

// File: bench/iprc_testbench.sv
/*
 * Self-checking bench for the priority register block.
 * Assumes one 100 MHz clock and the one-cycle Wishbone answer of the slave.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iprc_pkg::*;
    // Clock, bus and source signals
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cyc = 1'b0;
    logic              stb = 1'b0;
    logic              we = 1'b0;
    logic [7:0]        adr = 8'h00;
    logic [3:0]        sel = 4'h0;
    logic [31:0]       dat = 32'h0000_0000;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    iprc_src_t         req = '0;
    iprc_prio_t        prio_o;
    iprc_win_t         win_o;
    int                failures = 0;
    int                num_checks = 0;
    // Free-running clock
    always #5 clk_i = ~clk_i;
    iprc_regblock dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .req_i(req), .prio_o(prio_o), .win_o(win_o));
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; holds everything until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        // No local limit on the wait; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Taken on the first edge, answered on the next
        check("ack latency", n, 32'h0000_0002);
    endtask
    // Reset image, unmapped read
    task automatic t_reset();
        logic [31:0] q;
        check("prio_o", {23'h0, prio_o}, 32'h0000_0124);
        check("win_o", {26'h0, win_o}, 32'h0000_0000);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("reset read", q, 32'h0000_0444);
        xfer(1'b0, 8'h08, 4'hF, 32'h0, q);
        check("unmapped read", q, 32'h0000_0000);
        $display("test reset done");
    endtask
    // Field widths, read-zero bits, byte lanes
    task automatic t_fields();
        logic [31:0] q;
        xfer(1'b1, IPRC_PRIO_OFFSET, 4'hF, 32'hFFFF_FFFF, q);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("all ones", q, 32'h0000_0777);
        xfer(1'b1, IPRC_PRIO_OFFSET, 4'h2, 32'h0000_0000, q);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("lane 1 clear", q, 32'h0000_0077);
        xfer(1'b1, IPRC_PRIO_OFFSET, 4'h1, 32'h0000_0725, q);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("lane 0 write", q, 32'h0000_0025);
        xfer(1'b1, IPRC_PRIO_OFFSET, 4'hF, 32'h0000_0352, q);
        check("prio_o", {23'h0, prio_o}, 32'h0000_00EA);
        xfer(1'b1, IPRC_STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF, q);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("status write", q, 32'h0000_0352);
        $display("test fields done");
    endtask
    // Arbitration for one setting
    task automatic arb(input logic [31:0] p, input logic [2:0] r, input logic [5:0] e);
        logic [31:0] q;
        xfer(1'b1, IPRC_PRIO_OFFSET, 4'hF, p, q);
        req <= r;
        repeat (3) @(posedge clk_i);
        check("win_o", {26'h0, win_o}, {26'h0, e});
        xfer(1'b0, IPRC_STATUS_OFFSET, 4'hF, 32'h0, q);
        check("status read", q, {26'h0, e});
    endtask
    // Level table: highest, lowest, ties, disabled
    task automatic t_levels();
        arb(32'h0000_0171, 3'b111, 6'b101111);
        arb(32'h0000_0777, 3'b111, 6'b110111);
        arb(32'h0000_0001, 3'b111, 6'b100001);
        arb(32'h0000_0033, 3'b111, 6'b101011);
        arb(32'h0000_0500, 3'b100, 6'b110101);
        arb(32'h0000_0070, 3'b001, 6'b000000);
        req <= '0;
        $display("test levels done");
    endtask
    // Reset in mid-run: fields return to level 4, bus answers again
    task automatic t_midreset();
        logic [31:0] q;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("prio_o after reset", {23'h0, prio_o}, 32'h0000_0124);
        check("win_o after reset", {26'h0, win_o}, 32'h0000_0000);
        xfer(1'b0, IPRC_PRIO_OFFSET, 4'hF, 32'h0, q);
        check("read after reset", q, 32'h0000_0444);
        $display("test midreset done");
    endtask
    // Verdict
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_fields();
        t_levels();
        t_midreset();
        conclude();
    end
    // Watchdog; the tests need well under a thousand cycles
    initial begin
        #20000;
        failures++;
        conclude();
    end
endmodule // testbench
